// ---- common/fwi_regs.vh ----
// Register offsets, field positions and reset values of the flash write-enable interlock
`ifndef FWI_REGS_VH
`define FWI_REGS_VH
// Register byte offsets
`define FWI_CTRL_A_OFS   8'h00
`define FWI_CTRL_B_OFS   8'h04
`define FWI_STATUS_OFS   8'h08
`define FWI_OVERLAY_OFS  8'h0C
// Control register field positions
`define FWI_SWE_BIT  6
`define FWI_ESU_BIT  5
`define FWI_PSU_BIT  4
`define FWI_EV_BIT   3
`define FWI_PV_BIT   2
`define FWI_E_BIT    1
`define FWI_P_BIT    0
`define FWI_CTRL_W   7
`define FWI_CTRL_RST 7'h00
// Status register field positions
`define FWI_ST_WE     0
`define FWI_ST_PROT   1
`define FWI_ST_PGM_A  2
`define FWI_ST_ERS_A  3
`define FWI_ST_PGM_B  4
`define FWI_ST_ERS_B  5
`define FWI_ST_FETCH  6
`define FWI_ST_RST    7
`define FWI_ST_MODE   8
// Bus responses
`define FWI_RESP_OKAY   2'h0
`define FWI_RESP_SLVERR 2'h2
// Reset low time that the outside must honour, in system clocks
`define FWI_RESET_MIN_CLK 20
`endif

// ---- core/fwi_interlock.v ----
// Flash write-enable interlock with AXI4-Lite control registers
// Behaviour
// R01 - Write-enable pin low forces hardware protection
// R02 - Software enable allows only verify accesses
// R03 - Overlay RAM accesses pass regardless of enable
// R04 - Software leaves enable alone while running flash
// R05 - Outside holds reset low twenty clocks
// R06 - Boot mode: pin changes only during reset
// R07 - Pins stable for setup before reset release
// R08 - User program mode: pin switchable anytime
// R09 - Pin switching tolerated during flash execution
// R10 - Pin applied only after oscillator settles
// R11 - Pin released only with all bits clear
// R12 - Pin high only during program or erase
// R13 - No data moves during program or erase
// R14 - Start watchdog before setting setup bits
// R15 - Interrupts disabled while pin is high
// R16 - Each 128-byte unit programmed once per erase
// R17 - Program/erase bits cleared on protection events
// R18 - Overlay select blocks program and erase entry
// R19 - Pins synchronised before use
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`include "fwi_regs.vh"
`default_nettype none
module fwi_interlock #(
  parameter MODE_W = 3
) (
  // Clock, enable, reset
  input  wire              core_clk_i,
  input  wire              ce_i,
  input  wire              rst_n_i,
  // External pins
  input  wire              flash_write_enable_pin_i,
  input  wire              reset_pin_n_i,
  input  wire [MODE_W-1:0] mode_select_pins_i,
  // System events
  input  wire              wdt_reset_i,
  input  wire              standby_i,
  // Flash access request classification
  input  wire              flash_req_i,
  input  wire              flash_req_verify_i,
  input  wire              flash_req_overlay_i,
  // AXI4-Lite write address
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [7:0]        s_axi_awaddr,
  // AXI4-Lite write data
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  // AXI4-Lite write response
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  output reg  [1:0]        s_axi_bresp,
  // AXI4-Lite read address
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  input  wire [7:0]        s_axi_araddr,
  // AXI4-Lite read data
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  // Flash array controls
  output reg               flash_access_ok_o,
  output reg               program_active_o,
  output reg               erase_active_o,
  output reg               hw_protect_o
);
  localparam CW = `FWI_CTRL_W;

  wire [MODE_W+1:0] pins_s;
  wire              we_s;
  wire              rstpin_s;
  wire [MODE_W-1:0] mode_s;

  reg [CW-1:0] ctrl_a_r;
  reg [CW-1:0] ctrl_b_r;
  reg          overlay_r;
  reg [7:0]    awaddr_r;
  reg [31:0]   wdata_r;
  reg [3:0]    wstrb_r;
  reg          aw_have_r;
  reg          w_have_r;

  // Pins pass through a synchroniser before the interlock sees them
  fwi_sync #(.W(MODE_W+2), .RST_VAL({2'b01, {MODE_W{1'b0}}})) u_sync ( // R19
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .async_i    ({flash_write_enable_pin_i, reset_pin_n_i, mode_select_pins_i}),
    .sync_o     (pins_s)
  );
  assign we_s     = pins_s[MODE_W+1];
  assign rstpin_s = pins_s[MODE_W];
  assign mode_s   = pins_s[MODE_W-1:0];

  // Decoded byte address to register index
  function [2:0] fwi_dec;
    input [7:0] a;
    begin
      case (a)
        `FWI_CTRL_A_OFS:  fwi_dec = 3'h1;
        `FWI_CTRL_B_OFS:  fwi_dec = 3'h2;
        `FWI_STATUS_OFS:  fwi_dec = 3'h3;
        `FWI_OVERLAY_OFS: fwi_dec = 3'h4;
        default:          fwi_dec = 3'h0;
      endcase
    end
  endfunction

  // Protection: pin low, reset pin, watchdog reset or standby
  wire prot_clr = !we_s || !rstpin_s || wdt_reset_i || standby_i; // R01 R17
  // User program mode accepts pin changes at any time, no extra gating R08 R09

  // Clear program/erase bits whenever protection or enable loss applies
  function [CW-1:0] fwi_mask;
    input [CW-1:0] v;
    input          clr;
    begin
      fwi_mask = v;
      if (clr || !v[`FWI_SWE_BIT])
      begin
        fwi_mask[`FWI_P_BIT] = 1'b0; // R17
        fwi_mask[`FWI_E_BIT] = 1'b0; // R17
      end
    end
  endfunction

  // Merge written byte lane 0 into a control register
  function [CW-1:0] fwi_wr;
    input [CW-1:0] old;
    input [31:0]   d;
    input [3:0]    s;
    begin
      fwi_wr = s[0] ? d[CW-1:0] : old;
    end
  endfunction

  wire do_wr = aw_have_r && w_have_r && !s_axi_bvalid;
  wire [2:0] wsel = fwi_dec(awaddr_r);
  wire [CW-1:0] ctrl_a_nxt = fwi_mask((do_wr && wsel == 3'h1) ?
                             fwi_wr(ctrl_a_r, wdata_r, wstrb_r) : ctrl_a_r, prot_clr);
  wire [CW-1:0] ctrl_b_nxt = fwi_mask((do_wr && wsel == 3'h2) ?
                             fwi_wr(ctrl_b_r, wdata_r, wstrb_r) : ctrl_b_r, prot_clr);
  wire swe_any = ctrl_a_r[`FWI_SWE_BIT] || ctrl_b_r[`FWI_SWE_BIT];

  // Status word gathered from block state
  wire [31:0] status_w = {{(24-MODE_W){1'b0}}, mode_s, !rstpin_s, flash_access_ok_o,
                          ctrl_b_r[`FWI_E_BIT], ctrl_b_r[`FWI_P_BIT],
                          ctrl_a_r[`FWI_E_BIT], ctrl_a_r[`FWI_P_BIT],
                          hw_protect_o, we_s};

  // Write channel: address and data taken in either order, then response
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FWI_RESP_OKAY;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      ctrl_a_r      <= `FWI_CTRL_RST;
      ctrl_b_r      <= `FWI_CTRL_RST;
      overlay_r     <= 1'b0;
    end
    else if (ce_i)
    begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      ctrl_a_r <= ctrl_a_nxt;
      ctrl_b_r <= ctrl_b_nxt;
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == 3'h0 || wsel == 3'h3) ? `FWI_RESP_SLVERR : `FWI_RESP_OKAY;
        if (wsel == 3'h4 && wstrb_r[0])
          overlay_r <= wdata_r[0];
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, answer one cycle after address
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `FWI_RESP_OKAY;
    end
    else if (ce_i)
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `FWI_RESP_OKAY;
        case (fwi_dec(s_axi_araddr))
          3'h1:    s_axi_rdata <= {25'h0000000, ctrl_a_r};
          3'h2:    s_axi_rdata <= {25'h0000000, ctrl_b_r};
          3'h3:    s_axi_rdata <= status_w;
          3'h4:    s_axi_rdata <= {31'h00000000, overlay_r};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `FWI_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Flash array gating outputs
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      flash_access_ok_o <= 1'b0;
      program_active_o  <= 1'b0;
      erase_active_o    <= 1'b0;
      hw_protect_o      <= 1'b1;
    end
    else if (ce_i)
    begin
      hw_protect_o      <= prot_clr; // R01
      // Overlay always served; with enable set only verify accesses R02 R03
      flash_access_ok_o <= flash_req_i && (flash_req_overlay_i || !swe_any ||
                           flash_req_verify_i);
      program_active_o  <= !prot_clr && !overlay_r && // R18
                           ((ctrl_a_nxt[`FWI_P_BIT]) || (ctrl_b_nxt[`FWI_P_BIT]));
      erase_active_o    <= !prot_clr && !overlay_r && // R18
                           ((ctrl_a_nxt[`FWI_E_BIT]) || (ctrl_b_nxt[`FWI_E_BIT]));
    end
  end
endmodule // fwi_interlock
`default_nettype wire

// ---- core/fwi_sync.v ----
// Two flip-flop synchroniser for a vector of pin levels
`default_nettype none
module fwi_sync #(
  parameter W     = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock, enable and reset
  input  wire         core_clk_i,
  input  wire         rst_n_i,
  input  wire         ce_i,
  // Data
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // First stage feeds only the second stage
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end
    else if (ce_i)
    begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule // fwi_sync
`default_nettype wire

// ---- dv/fwi_interlock_chk.sv ----
// Checker for the interlock protection and grant outputs
`default_nettype none
module fwi_interlock_chk (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Pins and events
  input wire logic flash_write_enable_pin_i,
  input wire logic reset_pin_n_i,
  input wire logic wdt_reset_i,
  input wire logic standby_i,
  // Requests and results
  input wire logic flash_req_i,
  input wire logic flash_req_verify_i,
  input wire logic flash_req_overlay_i,
  input wire logic flash_access_ok_o,
  input wire logic program_active_o,
  input wire logic erase_active_o,
  input wire logic hw_protect_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Pin levels held long enough to cross the synchroniser
  sequence s_we_low; !flash_write_enable_pin_i [*4]; endsequence
  sequence s_rst_low; !reset_pin_n_i [*4]; endsequence
  sequence s_pe_off; !program_active_o && !erase_active_o; endsequence
  property p_prot; s_we_low |-> hw_protect_o; endproperty
  a_prot: assert property (p_prot)
    else $error("protect missing with pin low");
  property p_we_pe; s_we_low |=> s_pe_off; endproperty
  a_we_pe: assert property (p_we_pe)
    else $error("active with pin low");
  property p_rst_pe; s_rst_low |=> s_pe_off; endproperty
  a_rst_pe: assert property (p_rst_pe)
    else $error("active with reset pin low");
  property p_evt; wdt_reset_i || standby_i |=> s_pe_off; endproperty
  a_evt: assert property (p_evt)
    else $error("active after watchdog or standby");
  property p_ovl; flash_req_i && flash_req_overlay_i |=> flash_access_ok_o; endproperty
  a_ovl: assert property (p_ovl)
    else $error("overlay access refused");
  property p_ver; flash_req_i && flash_req_verify_i |=> flash_access_ok_o; endproperty
  a_ver: assert property (p_ver)
    else $error("verify access refused");
  property p_idle; !flash_req_i |=> !flash_access_ok_o; endproperty
  a_idle: assert property (p_idle)
    else $error("grant without request");
  property p_sync; $fell(hw_protect_o) |-> $past(flash_write_enable_pin_i, 3); endproperty
  a_sync: assert property (p_sync)
    else $error("protect dropped too early");
endmodule // fwi_interlock_chk
bind fwi_interlock fwi_interlock_chk u_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reset_pin_n_i(reset_pin_n_i),
  .flash_write_enable_pin_i(flash_write_enable_pin_i), .wdt_reset_i(wdt_reset_i),
  .standby_i(standby_i), .flash_req_i(flash_req_i), .flash_req_verify_i(flash_req_verify_i),
  .flash_req_overlay_i(flash_req_overlay_i), .flash_access_ok_o(flash_access_ok_o),
  .program_active_o(program_active_o), .erase_active_o(erase_active_o),
  .hw_protect_o(hw_protect_o));
`default_nettype wire

// ---- dv/fwi_pins_model.sv ----
// Board model driving the write-enable, reset and mode pins
`default_nettype none
module fwi_pins_model #(
  parameter int OSC_CLK = 8,
  parameter int RST_CLK = 20
) (
  // Clock and pins
  input  wire logic       core_clk_i,
  output var  logic       we_o,
  output var  logic       rst_pin_n_o,
  output var  logic [2:0] mode_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Power-on reset covers oscillator settling, pin kept low
  initial
  begin
    we_o = 1'b0;
    mode_o = 3'h0;
    rst_pin_n_o = 1'b0;
    repeat (OSC_CLK) @(posedge core_clk_i);
    rst_pin_n_o <= 1'b1;
  end
  // User program mode: pin may move at any edge
  task automatic set_we(input logic v);
    @(posedge core_clk_i);
    we_o <= v;
  endtask
  // Boot entry: pins move inside reset and settle before release
  task automatic boot_reset(input logic v, input logic [2:0] md);
    @(posedge core_clk_i);
    rst_pin_n_o <= 1'b0;
    @(posedge core_clk_i);
    we_o <= v;
    mode_o <= md;
    repeat (RST_CLK) @(posedge core_clk_i);
    rst_pin_n_o <= 1'b1;
  endtask
endmodule // fwi_pins_model
`default_nettype wire

// ---- dv/test_flash_write_enable_interlock.sv ----
// Self-checking bench for the flash write-enable interlock
`include "fwi_regs.vh"
`default_nettype none
module test_flash_write_enable_interlock;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, ce, wdt, stby, req, ver, ovl, awv, wv, bre, arv, rre;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, seed;
  logic [3:0]  ws;
  logic [1:0]  rsp;
  wire logic   awr, wr, bv, arr, rv, fok, pga, era, prot, we_pin, rpin_n;
  wire logic [2:0]  md;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdat;
  int          fails, n_checks;
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  fwi_pins_model u_pins (.core_clk_i(clk), .we_o(we_pin), .rst_pin_n_o(rpin_n), .mode_o(md));
  fwi_interlock uut (.core_clk_i(clk), .ce_i(ce), .rst_n_i(rst_n),
    .flash_write_enable_pin_i(we_pin), .reset_pin_n_i(rpin_n), .mode_select_pins_i(md),
    .wdt_reset_i(wdt), .standby_i(stby), .flash_req_i(req), .flash_req_verify_i(ver),
    .flash_req_overlay_i(ovl), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .flash_access_ok_o(fok),
    .program_active_o(pga), .erase_active_o(era), .hw_protect_o(prot));
  // Expected control word: program and erase drop without both enables
  function automatic logic [31:0] ctl(input logic [6:0] d, input logic we);
    return {25'h0, (we && d[6]) ? d : (d & 7'h7C)};
  endfunction
  function automatic logic grant(input logic q, v, o, en);
    return q && (o || !en || v);
  endfunction
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Comparisons and verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tmo(input int k);
    if (k >= 60)
    begin
      chk("handshake", 32'h1, 32'h0);
      conclude();
    end
  endtask
  // Bus master: write and read, each waiting for its answer
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge clk);
    {awv, wv, bre, awa, wd} <= {3'h7, a, d};
    do
    begin
      @(posedge clk);
      k++;
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1 && k < 60);
    bre <= 1'b0;
    tmo(k);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic axr(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge clk);
    {arv, rre, ara} <= {2'h3, a};
    do
    begin
      @(posedge clk);
      k++;
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1 && k < 60);
    {rd, rsp} = {rdat, rresp};
    rre <= 1'b0;
    tmo(k);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    axr(a);
    chk(nm, e, rd);
  endtask
  task automatic probe(input logic q, v, o, en);
    @(posedge clk);
    {req, ver, ovl} <= {q, v, o};
    @(posedge clk);
    req <= 1'b0;
    #1 chkb("grant", grant(q, v, o, en), fok);
  endtask
  // Main sequence
  initial
  begin
    {rst_n, wdt, stby, req, ver, ovl, awv, wv, bre, arv, rre} = 11'h0;
    {awa, ara, wd, ws, ce} = {8'h00, 8'h00, 32'h00000000, 4'hF, 1'b1};
    seed = 32'h0001763B;
    fails = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge clk);
    chkb("protect", 1'b1, prot);
    rdc("status", `FWI_STATUS_OFS, 32'h2);
    axw(`FWI_CTRL_A_OFS, 32'h41, `FWI_RESP_OKAY);
    rdc("ctrl_a", `FWI_CTRL_A_OFS, ctl(7'h41, 1'b0));
    axw(`FWI_CTRL_A_OFS, 32'h0, `FWI_RESP_OKAY);
    $display("test protect done");
    u_pins.set_we(1'b1);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 24; i++)
    begin
      seed = nxt(seed);
      axw(`FWI_CTRL_A_OFS, {25'h0, seed[6:0]}, `FWI_RESP_OKAY);
      rdc("ctrl_a", `FWI_CTRL_A_OFS, ctl(seed[6:0], 1'b1));
      chkb("program", seed[6] & seed[0], pga);
      chkb("erase", seed[6] & seed[1], era);
      probe(seed[8], seed[9] | (seed[6] & (seed[0] | seed[1])), seed[10], seed[6]);
    end
    $display("test random done");
    axw(`FWI_CTRL_A_OFS, 32'h41, `FWI_RESP_OKAY);
    axw(`FWI_OVERLAY_OFS, 32'h1, `FWI_RESP_OKAY);
    rdc("overlay", `FWI_OVERLAY_OFS, 32'h1);
    chkb("program", 1'b0, pga);
    probe(1'b1, 1'b0, 1'b1, 1'b1);
    probe(1'b1, 1'b1, 1'b0, 1'b1);
    axw(`FWI_OVERLAY_OFS, 32'h0, `FWI_RESP_OKAY);
    rdc("overlay", `FWI_OVERLAY_OFS, 32'h0);
    chkb("program", 1'b1, pga);
    $display("test overlay done");
    for (int j = 0; j < 2; j++)
    begin
      awa <= j ? `FWI_CTRL_B_OFS : `FWI_CTRL_A_OFS;
      axw(j ? `FWI_CTRL_B_OFS : `FWI_CTRL_A_OFS, 32'h40 | (32'h1 << j), `FWI_RESP_OKAY);
      chkb("active", 1'b1, j ? era : pga);
      {stby, wdt} <= j ? 2'b10 : 2'b01;
      @(posedge clk);
      {stby, wdt} <= 2'b00;
      rdc("ctrl", j ? `FWI_CTRL_B_OFS : `FWI_CTRL_A_OFS, 32'h40);
      chkb("active", 1'b0, j ? era : pga);
      axw(j ? `FWI_CTRL_B_OFS : `FWI_CTRL_A_OFS, 32'h0, `FWI_RESP_OKAY);
    end
    $display("test events done");
    axw(`FWI_STATUS_OFS, 32'hFFFFFFFF, `FWI_RESP_SLVERR);
    axr(8'h10);
    chk("rdata", 32'h0, rd);
    chk("rresp", {30'h0, `FWI_RESP_SLVERR}, {30'h0, rsp});
    $display("test refusal done");
    // Clock enable low: a plain request must not reach the grant
    ce <= 1'b0;
    {req, ver, ovl} <= 3'b100;
    repeat (3) @(posedge clk);
    chkb("frozen", 1'b0, fok);
    {ce, req} <= 2'b10;
    probe(1'b1, 1'b0, 1'b0, 1'b0);
    $display("test enable done");
    u_pins.set_we(1'b0);
    repeat (4) @(posedge clk);
    chkb("protect", 1'b1, prot);
    u_pins.boot_reset(1'b1, 3'h2);
    repeat (4) @(posedge clk);
    rdc("status", `FWI_STATUS_OFS, 32'h201);
    $display("test boot done");
    conclude();
  end
endmodule // test_flash_write_enable_interlock
`default_nettype wire
